// [otg_line_pkg.sv]
// package for the otg line and vbus boost control block
// Behaviour
// R1: pull-up bit connects full-speed d+ pull-up
// R2: pull-down bits connect d+/d- pull-downs
// R3: software checks power, discharge before boost
// R4: pwm period bits 7:0, duty 15:8
// R5: pwm polarity follows control bit 9
// R6: vbus target chosen by otg bit 1
// R7: counter runs only while bit 8 set
// R8: pwm active only while bit 15 set
// R9: software enables vbus generation last
// R10: pwm drives supply, comparators guard output
// R11: software waits for vbus before pull-up
// R12: software keeps pull-up during suspend
// R13: output high to duty, low to period
// assumes a single 50 mhz clock and a plain strobe register port
`default_nettype none

package otg_line_pkg;

	// ------------------------------------------------------------
	// register offsets (word index, 16-bit registers)
	// ------------------------------------------------------------
	localparam logic [3:0] otg_line_control_off   = 4'h0;
	localparam logic [3:0] usb_power_control_off  = 4'h1;
	localparam logic [3:0] boost_period_duty_off  = 4'h2;
	localparam logic [3:0] boost_pwm_control_off  = 4'h3;
	localparam logic [3:0] boost_status_off       = 4'h4;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int dplus_pullup_pos     = 7;
	localparam int dplus_pulldown_pos   = 5;
	localparam int dminus_pulldown_pos  = 4;
	localparam int vbus_gen_enable_pos  = 3;
	localparam int vbus_target_pos      = 1;
	localparam int vbus_discharge_pos   = 0;
	localparam int usb_power_pos        = 0;
	localparam int boost_pwm_enable_pos = 15;
	localparam int boost_polarity_pos   = 9;
	localparam int boost_counter_pos    = 8;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [15:0] otg_line_control_rst  = 16'h0000;
	localparam logic [15:0] usb_power_control_rst = 16'h0000;
	localparam logic [15:0] boost_period_duty_rst = 16'h0000;
	localparam logic [15:0] boost_pwm_control_rst = 16'h0000;

	// ------------------------------------------------------------
	// grouped line controls towards the pads
	// ------------------------------------------------------------
	typedef struct packed {
		logic dplus_pullup_enable;
		logic dplus_pulldown_enable;
		logic dminus_pulldown_enable;
	} line_ctrl_type;

	// analog comparator results from the boost stage
	typedef struct packed {
		logic vbus_above_target;
		logic current_limit;
	} boost_cmp_type;

endpackage

`default_nettype wire

// [boost_pwm_gen.sv]
// pwm counter for the vbus boost assist
// assumes period and duty are held stable by the caller
`default_nettype none

module boost_pwm_gen
	import otg_line_pkg::*;
(
	// clock, reset and enable
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	input  wire logic       clk_en,
	// settings
	input  wire logic       count_enable,
	input  wire logic [7:0] period,
	input  wire logic [7:0] duty,
	// result, true-high before polarity
	output logic            pwm_raw
);

	logic [7:0] count_q;  // running count

	// ------------------------------------------------------------
	// counter restarts after reaching period
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			count_q <= 8'h00;
		end else if (clk_en) begin
			if (!count_enable) begin
				count_q <= 8'h00;  // cleared to zero while stopped, see R7
			end else if (count_q >= period) begin
				count_q <= 8'h00;  // restart, see R4
			end else begin
				count_q <= count_q + 8'h01;
			end
		end
	end

	// high from restart until duty, then low, see R13
	assign pwm_raw = count_enable && (count_q < duty);

	// checks share the one clock and pause during reset
	default clocking chk_cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	a_count_bound : assert property ( // see R4
		count_enable && clk_en && count_q >= period |=> count_q == 8'h00)
		else $error("pwm counter did not restart");

endmodule

`default_nettype wire

// [otg_line_ctrl.sv]
// top of the otg line pull and vbus boost control block
// assumes software obeys the enable order for boost start
//
// Implementation choices: the register offsets and the address-and-strobe port.
`default_nettype none

module otg_line_ctrl
	import otg_line_pkg::*;
(
	// clock, reset, enable
	input  wire logic          sys_clk,
	input  wire logic          nrst,
	input  wire logic          clk_en,
	// register port
	input  wire logic [3:0]    reg_addr,
	input  wire logic [15:0]   reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output logic [15:0]        reg_rdata,
	// comparators from the external boost stage
	input  wire boost_cmp_type boost_cmp,
	// pads and supply
	output line_ctrl_type      line_ctrl,
	output logic               boost_pwm_out,
	output logic               vbus_target_high,
	output logic               vbus_gen_active
);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [15:0] otg_line_control_q;    // pulls, target, vbus gen
	logic [15:0] usb_power_control_q;   // module power
	logic [15:0] boost_period_duty_q;   // period low, duty high
	logic [15:0] boost_pwm_control_q;   // enable, polarity, counter
	logic [1:0]  cmp_q;                 // registered comparator view
	logic        pwm_raw;               // counter result

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			otg_line_control_q  <= otg_line_control_rst;
			usb_power_control_q <= usb_power_control_rst;
			boost_period_duty_q <= boost_period_duty_rst;
			boost_pwm_control_q <= boost_pwm_control_rst;
		end else if (clk_en && reg_wr) begin
			unique case (reg_addr)
				otg_line_control_off:  otg_line_control_q  <= reg_wdata;
				usb_power_control_off: usb_power_control_q <= reg_wdata;
				boost_period_duty_off: boost_period_duty_q <= reg_wdata;
				boost_pwm_control_off: boost_pwm_control_q <= reg_wdata;
				default: ;  // unmapped writes are dropped
			endcase
		end
	end

	// ------------------------------------------------------------
	// read port, data one cycle after the strobe
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			reg_rdata <= 16'h0000;
		end else if (clk_en) begin
			if (!reg_rd) begin
				reg_rdata <= 16'h0000;  // only valid after a read
			end else begin
				unique case (reg_addr)
					otg_line_control_off:  reg_rdata <= otg_line_control_q;
					usb_power_control_off: reg_rdata <= usb_power_control_q;
					boost_period_duty_off: reg_rdata <= boost_period_duty_q;
					boost_pwm_control_off: reg_rdata <= boost_pwm_control_q;
					// live comparator state, see R10
					boost_status_off:      reg_rdata <= {14'h0000, cmp_q};
					default:               reg_rdata <= 16'h0000;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// pwm counter
	// ------------------------------------------------------------
	boost_pwm_gen u_pwm (
		.sys_clk      (sys_clk),
		.nrst         (nrst),
		.clk_en       (clk_en),
		.count_enable (boost_pwm_control_q[boost_counter_pos]), // see R7
		.period       (boost_period_duty_q[7:0]),                // see R4
		.duty         (boost_period_duty_q[15:8]),               // see R4
		.pwm_raw      (pwm_raw)
	);

	// ------------------------------------------------------------
	// outputs, each from a flip-flop
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			line_ctrl        <= '0;
			boost_pwm_out    <= 1'b0;
			vbus_target_high <= 1'b0;
			vbus_gen_active  <= 1'b0;
			cmp_q            <= 2'b00;
		end else if (clk_en) begin
			cmp_q <= boost_cmp;
			// pull resistors straight from the control bits
			line_ctrl.dplus_pullup_enable <=
				otg_line_control_q[dplus_pullup_pos];     // see R1
			line_ctrl.dplus_pulldown_enable <=
				otg_line_control_q[dplus_pulldown_pos];   // see R2
			line_ctrl.dminus_pulldown_enable <=
				otg_line_control_q[dminus_pulldown_pos];  // see R2
			vbus_target_high <=
				otg_line_control_q[vbus_target_pos];      // see R6
			vbus_gen_active <=
				otg_line_control_q[vbus_gen_enable_pos];
			// idle level is the inactive polarity; current limit cuts the
			// drive at once so a shorted bus does not keep the switch on
			if (boost_pwm_control_q[boost_pwm_enable_pos] &&
				!boost_cmp.current_limit && !boost_cmp.vbus_above_target) begin
				boost_pwm_out <= pwm_raw ^
					boost_pwm_control_q[boost_polarity_pos]; // see R5, R8, R10
			end else begin
				boost_pwm_out <= boost_pwm_control_q[boost_polarity_pos];
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// all checks live in the one clock domain and pause during reset
	default clocking chk_cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	a_pullup_follow : assert property ( // see R1
		clk_en |=> line_ctrl.dplus_pullup_enable ==
			$past(otg_line_control_q[dplus_pullup_pos]))
		else $error("d+ pull-up does not follow control bit");

	a_pulldown_follow : assert property ( // see R2
		clk_en |=> line_ctrl.dminus_pulldown_enable ==
			$past(otg_line_control_q[dminus_pulldown_pos]))
		else $error("d- pull-down does not follow control bit");

	a_target_follow : assert property ( // see R6
		clk_en |=> vbus_target_high ==
			$past(otg_line_control_q[vbus_target_pos]))
		else $error("vbus target does not follow control bit");

	a_pwm_idle_off : assert property ( // see R8
		clk_en && !boost_pwm_control_q[boost_pwm_enable_pos] |=>
			boost_pwm_out ==
			$past(boost_pwm_control_q[boost_polarity_pos]))
		else $error("pwm output toggles while disabled");

	// a stopped counter must leave the pin at its idle level
	a_counter_stop : assert property ( // see R7
		clk_en && !boost_pwm_control_q[boost_counter_pos] |=>
			boost_pwm_out ==
			$past(boost_pwm_control_q[boost_polarity_pos]))
		else $error("pwm active while counter stopped");

	a_pwm_polarity : assert property ( // see R5
		clk_en && boost_pwm_control_q[boost_pwm_enable_pos] &&
			boost_cmp == 2'b00 |=>
			boost_pwm_out == ($past(pwm_raw) ^
			$past(boost_pwm_control_q[boost_polarity_pos])))
		else $error("pwm polarity wrong");

	a_current_cut : assert property ( // see R10
		clk_en && boost_cmp.current_limit |=>
			boost_pwm_out ==
			$past(boost_pwm_control_q[boost_polarity_pos]))
		else $error("pwm drives during current limit");

	// zero duty with the output live: the pin must sit at idle level
	sequence s_duty_zero;
		clk_en && boost_pwm_control_q[boost_pwm_enable_pos] &&
			boost_period_duty_q[15:8] == 8'h00 && boost_cmp == 2'b00;
	endsequence
	sequence s_pwm_idle;
		boost_pwm_out == $past(boost_pwm_control_q[boost_polarity_pos]);
	endsequence
	a_duty_zero : assert property ( // see R13
		s_duty_zero |=> s_pwm_idle)
		else $error("pwm high with zero duty");

endmodule

`default_nettype wire

// [boost_stage_model.sv]
// model of the external boost supply and its two comparators
// assumes the bench raises over_v or over_i to provoke a fault
`default_nettype none

module boost_stage_model
	import otg_line_pkg::*;
(
	// supply state and fault commands
	input  wire logic     gen_on,
	input  wire logic     over_v,
	input  wire logic     over_i,
	// comparator levels back to the block
	output boost_cmp_type cmp
);
	timeunit 1ns;
	timeprecision 1ns;

	// a stage that is not generating cannot trip, so faults are gated
	// by the generation enable
	assign cmp.vbus_above_target = gen_on & over_v;
	assign cmp.current_limit     = gen_on & over_i;
endmodule

`default_nettype wire

// [testbench.sv]
// self-checking bench for the otg line and boost control block
// assumes a 50 mhz clock and the plain strobe register port
`default_nettype none

module testbench
	import otg_line_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------
	// signals
	// ----------------------------------------------------------
	logic          sys_clk, nrst, clk_en, reg_wr, reg_rd, ov, oi;
	logic [3:0]    reg_addr;
	logic [15:0]   reg_wdata, reg_rdata;
	boost_cmp_type cmp;
	line_ctrl_type line_ctrl;
	logic          boost_pwm_out, vbus_target_high, vbus_gen_active;
	int            num_errors, samples_checked, cyc;

	// one row: write, fault levels, readback, outputs, highs in 16
	typedef struct {
		logic [3:0]  a;
		logic [15:0] d;
		logic        ov, oi;
		logic [15:0] e;
		logic [4:0]  o, h;
	} row_type;

	// order follows the boost start sequence
	row_type rows [21] = '{
		'{4'h0, 16'h0080, 1'h0, 1'h0, 16'h0080, 5'h10, 5'h00},
		'{4'h0, 16'h0030, 1'h0, 1'h0, 16'h0030, 5'h0c, 5'h00},
		'{4'h0, 16'h0002, 1'h0, 1'h0, 16'h0002, 5'h02, 5'h00},
		'{4'h0, 16'h00b2, 1'h0, 1'h0, 16'h00b2, 5'h1e, 5'h00},
		'{4'h0, 16'h0000, 1'h0, 1'h0, 16'h0000, 5'h00, 5'h00},
		'{4'h1, 16'h0001, 1'h0, 1'h0, 16'h0001, 5'h00, 5'h00},
		'{4'h2, 16'h0103, 1'h0, 1'h0, 16'h0103, 5'h00, 5'h00},
		'{4'h3, 16'h0200, 1'h0, 1'h0, 16'h0200, 5'h00, 5'h10},
		'{4'h0, 16'h0002, 1'h0, 1'h0, 16'h0002, 5'h02, 5'h10},
		'{4'h3, 16'h0300, 1'h0, 1'h0, 16'h0300, 5'h02, 5'h10},
		'{4'h3, 16'h8300, 1'h0, 1'h0, 16'h8300, 5'h02, 5'h0c},
		'{4'h0, 16'h000a, 1'h0, 1'h0, 16'h000a, 5'h03, 5'h0c},
		'{4'h3, 16'h8100, 1'h0, 1'h0, 16'h8100, 5'h03, 5'h04},
		'{4'h2, 16'h0207, 1'h0, 1'h0, 16'h0207, 5'h03, 5'h04},
		'{4'h2, 16'h0503, 1'h0, 1'h0, 16'h0503, 5'h03, 5'h10},
		'{4'h2, 16'h0003, 1'h0, 1'h0, 16'h0003, 5'h03, 5'h00},
		'{4'h2, 16'h0103, 1'h1, 1'h0, 16'h0103, 5'h03, 5'h00},
		'{4'h2, 16'h0103, 1'h0, 1'h1, 16'h0103, 5'h03, 5'h00},
		'{4'h3, 16'h8300, 1'h0, 1'h1, 16'h8300, 5'h03, 5'h10},
		'{4'h4, 16'hffff, 1'h1, 1'h1, 16'h0003, 5'h03, 5'h10},
		'{4'h7, 16'hffff, 1'h0, 1'h0, 16'h0000, 5'h03, 5'h0c}
	};

	// ----------------------------------------------------------
	// design, far side and clock
	// ----------------------------------------------------------
	otg_line_ctrl dut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .boost_cmp(cmp),
		.line_ctrl(line_ctrl), .boost_pwm_out(boost_pwm_out),
		.vbus_target_high(vbus_target_high),
		.vbus_gen_active(vbus_gen_active));
	boost_stage_model partner (.gen_on(vbus_gen_active), .over_v(ov),
		.over_i(oi), .cmp(cmp));

	initial begin
		sys_clk = 1'h0;
		forever #10 sys_clk = ~sys_clk;
	end

	// ----------------------------------------------------------
	// tasks
	// ----------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'h1;
		@(posedge sys_clk);
		reg_wr    <= 1'h0;
	endtask

	// read data stand only in the cycle after the taken strobe
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'h1;
		@(posedge sys_clk);
		reg_rd   <= 1'h0;
		#1 d = reg_rdata;
	endtask

	task automatic settle();
		repeat (2) @(posedge sys_clk);
		#1;
	endtask

	// counts high cycles and toggles over 16 cycles
	task automatic meas(output logic [4:0] h, output logic [4:0] t);
		logic p;
		h = 5'h00;
		t = 5'h00;
		p = boost_pwm_out;
		repeat (16) begin
			@(posedge sys_clk);
			#1;
			h += 5'(boost_pwm_out);
			t += 5'(boost_pwm_out !== p);
			p = boost_pwm_out;
		end
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			finish_test();
		end
	end

	// ----------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------
	initial begin
		logic [15:0] d;
		logic [4:0]  h, t;
		{nrst, reg_wr, reg_rd, ov, oi} = 5'h00;
		clk_en    = 1'h1;
		reg_addr  = 4'h0;
		reg_wdata = 16'h0000;
		repeat (4) @(posedge sys_clk);
		nrst <= 1'h1;
		foreach (rows[i]) begin
			@(posedge sys_clk);
			ov <= rows[i].ov;
			oi <= rows[i].oi;
			wr(rows[i].a, rows[i].d);
			settle();
			chk(16'({line_ctrl, vbus_target_high, vbus_gen_active}),
				16'(rows[i].o));
			rd(rows[i].a, d);
			chk(d, rows[i].e);
			meas(h, t);
			chk(16'(h), 16'(rows[i].h));
		end
		// stopped counter, cleared to zero, holds the output still
		wr(4'h3, 16'h8000);
		settle();
		meas(h, t);
		chk(16'(t), 16'h0000);
		// strobes ignored while the clock enable is low
		@(posedge sys_clk);
		clk_en <= 1'h0;
		wr(4'h0, 16'h0080);
		clk_en <= 1'h1;
		settle();
		rd(4'h0, d);
		chk(d, 16'h000a);
		// reset in mid-run clears outputs and registers
		@(posedge sys_clk);
		nrst <= 1'h0;
		repeat (2) @(posedge sys_clk);
		nrst <= 1'h1;
		settle();
		chk(16'({line_ctrl, boost_pwm_out, vbus_gen_active}), 16'h0000);
		rd(4'h3, d);
		chk(d, 16'h0000);
		finish_test();
	end
endmodule

`default_nettype wire
